// *** design/wfx_top.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose : Network word field extraction stages and a single source selector
// Assumes : Config ports are quasi-static; writes arrive as one-cycle strobes
// Notes   : Staleness is measured in whole ticks of a shared millisecond timer
//////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01 - Stage outputs nothing unless its enable bit is one
// RULE_02 - Stage listens to one configured address inside a fixed window, 256 words
// RULE_03 - Field is word ANDed with size/position mask, shifted right by position
// RULE_04 - Mask bits falling beyond bit 15 are dropped, no neighbour bits
// RULE_05 - Field times resolution plus offset, applied last
// RULE_06 - No word for timeout milliseconds makes the output not available
// RULE_07 - Timeout of zero disables the staleness check
// RULE_08 - Source picked by kind code plus instance number
// RULE_09 - Kind zero means unused and disables the other settings
// RULE_10 - Function block kinds give data only once their enable is set
// RULE_11 - Trouble code kind valid only with nonzero suspect parameter id
// RULE_12 - Kind 13 selects receive stage one to ten
// RULE_13 - Binary input off at or below minimum, on at or above maximum
// RULE_14 - Between minimum and maximum the binary input holds its state
// RULE_15 - Not-available is a flag beside the value, cleared by new words
// RULE_16 - Millisecond tick from clock; age restarts on each matching write
`timescale 1ns/1ps

module wfx_top #(
  parameter int TICK_CYCLES = wfx_pkg::TICK_CYCLES,
  parameter int RX_COUNT    = wfx_pkg::RX_COUNT
) (
  input  wire logic                                                    SYS_CLK_I,
  input  wire logic                                                    RESETN_I,
  input  wire logic                                                    WR_STROBE_I,
  input  wire logic [15:0]                                             WR_ADDR_I,
  input  wire logic [wfx_pkg::WORD_W-1:0]                              WR_DATA_I,
  input  wire logic [RX_COUNT-1:0]                                     RX_ENABLE_I,
  input  wire logic [RX_COUNT-1:0][15:0]                               RX_ADDR_I,
  input  wire logic [RX_COUNT-1:0][wfx_pkg::SIZE_W-1:0]                RX_SIZE_I,
  input  wire logic [RX_COUNT-1:0][wfx_pkg::POS_W-1:0]                 RX_POS_I,
  input  wire logic [RX_COUNT-1:0][wfx_pkg::RES_W-1:0]                 RX_RES_I,
  input  wire logic [RX_COUNT-1:0][wfx_pkg::VAL_W-1:0]                 RX_OFFSET_I,
  input  wire logic [RX_COUNT-1:0][wfx_pkg::TMO_W-1:0]                 RX_TIMEOUT_I,
  input  wire logic [3:0]                                              SEL_KIND_I,
  input  wire logic [wfx_pkg::NUM_W-1:0]                               SEL_NUM_I,
  input  wire logic                                                    SEL_BINARY_I,
  input  wire logic [wfx_pkg::VAL_W-1:0]                               SEL_MIN_I,
  input  wire logic [wfx_pkg::VAL_W-1:0]                               SEL_MAX_I,
  input  wire logic [15:0][11:0][wfx_pkg::VAL_W-1:0]                   SRC_VALUE_I,
  input  wire logic [15:0][11:0]                                       SRC_ENABLE_I,
  input  wire logic [4:0][wfx_pkg::PID_W-1:0]                          TC_PARAM_ID_I,
  output logic      [RX_COUNT-1:0][wfx_pkg::VAL_W-1:0]                 RX_VALUE_O,
  output logic      [RX_COUNT-1:0]                                     RX_VALID_O,
  output logic      [wfx_pkg::VAL_W-1:0]                               SEL_VALUE_O,
  output logic                                                         SEL_VALID_O,
  output logic                                                         SEL_USED_O,
  output logic                                                         SEL_BIT_O
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [TICK_W-1:0]                                tick_cnt;
    logic                                             ms_tick;
    logic [RX_COUNT-1:0][wfx_pkg::WORD_W-1:0]         word;
    logic [RX_COUNT-1:0]                              got;
    logic [RX_COUNT-1:0]                              stale;
    logic [RX_COUNT-1:0][wfx_pkg::TMO_W-1:0]          age;
    logic [RX_COUNT-1:0][wfx_pkg::VAL_W-1:0]          value;
    logic [RX_COUNT-1:0]                              valid;
    logic [wfx_pkg::VAL_W-1:0]                        sel_value;
    logic                                             sel_valid;
    logic                                             sel_used;
    logic                                             sel_bit;
  } wfx_state_t;

  wfx_state_t state;
  wfx_state_t next_state;

  //////////////////////////////////////////////////////////////////////////////
  // Highest instance per kind
  function automatic logic [3:0] num_limit(input logic [3:0] kind);
    case (kind)
      wfx_pkg::WFX_K_RXMSG:   num_limit = wfx_pkg::NUM_RXMSG;
      wfx_pkg::WFX_K_CTRL:    num_limit = wfx_pkg::NUM_CTRL;
      wfx_pkg::WFX_K_TABLE:   num_limit = wfx_pkg::NUM_TABLE;
      wfx_pkg::WFX_K_MATH:    num_limit = wfx_pkg::NUM_MATH;
      wfx_pkg::WFX_K_LOGIC:   num_limit = wfx_pkg::NUM_LOGIC;
      wfx_pkg::WFX_K_TCODE:   num_limit = wfx_pkg::NUM_TCODE;
      wfx_pkg::WFX_K_TARGET:  num_limit = wfx_pkg::NUM_TARGET;
      wfx_pkg::WFX_K_CURRENT: num_limit = wfx_pkg::NUM_CURRENT;
      wfx_pkg::WFX_K_RXSTAGE: num_limit = wfx_pkg::NUM_RXSTAGE;
      default:                num_limit = wfx_pkg::NUM_NONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0]                   mask32;
    logic [wfx_pkg::WORD_W-1:0]    field;
    logic signed [48:0]            prod;
    logic [31:0]                   scaled;
    logic                          hit;
    logic [3:0]                    lim;
    logic [3:0]                    idx;
    logic                          in_range;
    logic [wfx_pkg::VAL_W-1:0]     src_val;
    logic                          src_ok;
    logic                          is_binary;
    mask32     = 32'h0;
    field      = 16'h0;
    prod       = 49'sh0;
    scaled     = 32'h0;
    hit        = 1'b0;
    lim        = 4'h0;
    idx        = 4'h0;
    in_range   = 1'b0;
    src_val    = 32'h0;
    src_ok     = 1'b0;
    is_binary  = 1'b0;
    next_state = state;

    // RULE_16 ms tick
    next_state.ms_tick = 1'b0;
    if (state.tick_cnt == TICK_LAST) begin
      next_state.tick_cnt = '0;
      next_state.ms_tick  = 1'b1;
    end else begin
      next_state.tick_cnt = state.tick_cnt + TICK_W'(1);
    end

    for (int i = 0; i < RX_COUNT; i++) begin
      // RULE_02 address window match
      hit = WR_STROBE_I && (WR_ADDR_I == RX_ADDR_I[i])
            && (RX_ADDR_I[i] >= wfx_pkg::ADDR_LO) && (RX_ADDR_I[i] <= wfx_pkg::ADDR_HI);
      if (!RX_ENABLE_I[i]) begin
        // RULE_01 disabled stage idle
        next_state.got[i]   = 1'b0;
        next_state.stale[i] = 1'b0;
        next_state.age[i]   = '0;
        next_state.value[i] = '0;
        next_state.valid[i] = 1'b0;
      end else begin
        if (hit) begin
          // RULE_15 new word wins over expiry
          next_state.word[i]  = WR_DATA_I;
          next_state.got[i]   = 1'b1;
          next_state.stale[i] = 1'b0;
          // RULE_16 age restart
          next_state.age[i]   = '0;
        end else if (state.ms_tick && state.got[i]) begin
          if (state.age[i] != '1) begin
            next_state.age[i] = state.age[i] + 16'h0001;
          end
          // RULE_06 timeout expiry
          // RULE_07 zero disables
          if ((RX_TIMEOUT_I[i] != 16'h0000)
              && ((state.age[i] + 17'h00001) >= {1'b0, RX_TIMEOUT_I[i]})) begin
            next_state.stale[i] = 1'b1;
          end
        end
        // RULE_03 mask and shift
        // RULE_04 outside bits dropped
        mask32 = ((32'h1 << RX_SIZE_I[i]) - 32'h1) << RX_POS_I[i];
        field  = (state.word[i] & mask32[15:0]) >> RX_POS_I[i];
        // RULE_05 scale then offset
        prod   = $signed({17'h0, field}) * $signed(RX_RES_I[i]);
        scaled = prod[31:0] + RX_OFFSET_I[i];
        next_state.value[i] = state.got[i] ? scaled : 32'h0;
        next_state.valid[i] = state.got[i] && !state.stale[i];
      end
    end

    // RULE_08 kind plus instance
    lim      = num_limit(SEL_KIND_I);
    idx      = (lim == 4'h0) ? 4'h0 : (SEL_NUM_I - 4'h1);
    in_range = (lim == 4'h0) || ((SEL_NUM_I != 4'h0) && (SEL_NUM_I <= lim));
    if (in_range) begin
      src_val = SRC_VALUE_I[SEL_KIND_I][idx];
    end
    case (SEL_KIND_I)
      wfx_pkg::WFX_K_RXMSG,
      wfx_pkg::WFX_K_CTRL,
      wfx_pkg::WFX_K_TABLE,
      wfx_pkg::WFX_K_MATH,
      wfx_pkg::WFX_K_LOGIC: begin
        // RULE_10 enable gates block
        src_ok = in_range && SRC_ENABLE_I[SEL_KIND_I][idx];
      end
      wfx_pkg::WFX_K_TCODE: begin
        // RULE_11 nonzero param id
        src_ok    = in_range && (TC_PARAM_ID_I[idx[2:0]] != '0);
        is_binary = 1'b1;
      end
      wfx_pkg::WFX_K_RXSTAGE: begin
        // RULE_12 receive stage pick
        src_ok  = in_range && (int'(idx) < RX_COUNT) && state.valid[idx];
        src_val = (in_range && (int'(idx) < RX_COUNT)) ? state.value[idx] : 32'h0;
      end
      wfx_pkg::WFX_K_CDISC: begin
        src_ok    = 1'b1;
        is_binary = 1'b1;
      end
      wfx_pkg::WFX_K_CCONT,
      wfx_pkg::WFX_K_TARGET,
      wfx_pkg::WFX_K_CURRENT,
      wfx_pkg::WFX_K_SUPPLY,
      wfx_pkg::WFX_K_TEMP: begin
        src_ok = in_range;
      end
      default: begin
        src_ok = 1'b0;
      end
    endcase

    if (SEL_KIND_I == wfx_pkg::WFX_K_UNUSED) begin
      // RULE_09 unused input
      next_state.sel_used  = 1'b0;
      next_state.sel_value = '0;
      next_state.sel_valid = 1'b0;
      next_state.sel_bit   = 1'b0;
    end else begin
      next_state.sel_used  = 1'b1;
      next_state.sel_value = src_ok ? src_val : 32'h0;
      next_state.sel_valid = src_ok;
      if (!src_ok || !SEL_BINARY_I) begin
        next_state.sel_bit = 1'b0;
      end else if (is_binary) begin
        next_state.sel_bit = (src_val != 32'h0);
      end else if ($signed(src_val) <= $signed(SEL_MIN_I)) begin
        // RULE_13 off at minimum
        next_state.sel_bit = 1'b0;
      end else if ($signed(src_val) >= $signed(SEL_MAX_I)) begin
        // RULE_13 on at maximum
        next_state.sel_bit = 1'b1;
      end else begin
        // RULE_14 hysteresis hold
        next_state.sel_bit = state.sel_bit;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign RX_VALUE_O  = state.value;
  assign RX_VALID_O  = state.valid;
  assign SEL_VALUE_O = state.sel_value;
  assign SEL_VALID_O = state.sel_valid;
  assign SEL_USED_O  = state.sel_used;
  assign SEL_BIT_O   = state.sel_bit;

endmodule // wfx_top

// *** design/wfx_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants and types for word field extract and source select
// Assumes : 200 MHz system clock, 16-bit network register words
// Notes   : Shared widths, counts and codes live here; address, kind, source and trouble code port sizes are literals in wfx_top
//////////////////////////////////////////////////////////////////////////////
package wfx_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Word and value widths
  localparam int WORD_W   = 16;
  localparam int SIZE_W   = 5;
  localparam int POS_W    = 4;
  localparam int RES_W    = 16;
  localparam int VAL_W    = 32;
  localparam int TMO_W    = 16;
  localparam int NUM_W    = 4;
  localparam int PID_W    = 19;

  //////////////////////////////////////////////////////////////////////////////
  // Receive stage instances and the writable register window
  localparam int             RX_COUNT = 10;
  localparam logic [15:0]    ADDR_LO  = 16'h0100;
  localparam logic [15:0]    ADDR_HI  = 16'h01FF;

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS         = 1000000000;
  localparam int TICK_CYCLES   = MS_PS / CLK_PERIOD_PS;

  //////////////////////////////////////////////////////////////////////////////
  // Source kind codes
  typedef enum logic [3:0] {
    WFX_K_UNUSED   = 4'h0,
    WFX_K_RXMSG    = 4'h1,
    WFX_K_CDISC    = 4'h2,
    WFX_K_CCONT    = 4'h3,
    WFX_K_CTRL     = 4'h4,
    WFX_K_TABLE    = 4'h5,
    WFX_K_MATH     = 4'h6,
    WFX_K_LOGIC    = 4'h7,
    WFX_K_TCODE    = 4'h8,
    WFX_K_TARGET   = 4'h9,
    WFX_K_CURRENT  = 4'hA,
    WFX_K_SUPPLY   = 4'hB,
    WFX_K_TEMP     = 4'hC,
    WFX_K_RXSTAGE  = 4'hD
  } wfx_kind_t;

  localparam int KIND_COUNT = 16;
  localparam int INST_MAX   = 12;

  // Highest instance number per kind; zero means the number is ignored
  localparam logic [3:0] NUM_RXMSG   = 4'hA;
  localparam logic [3:0] NUM_CTRL    = 4'h4;
  localparam logic [3:0] NUM_TABLE   = 4'hC;
  localparam logic [3:0] NUM_MATH    = 4'h6;
  localparam logic [3:0] NUM_LOGIC   = 4'h4;
  localparam logic [3:0] NUM_TCODE   = 4'h5;
  localparam logic [3:0] NUM_TARGET  = 4'hA;
  localparam logic [3:0] NUM_CURRENT = 4'hA;
  localparam logic [3:0] NUM_RXSTAGE = 4'hA;
  localparam logic [3:0] NUM_NONE    = 4'h0;

endpackage : wfx_pkg

// *** tb/wfx_assertions.sv ***
// Purpose: Port checks for field extract stage zero and the selector
// Assumes: Stage zero carries the traffic worth watching
// Notes: Other stages are judged by the bench only
`timescale 1ns/1ps
module wfx_assertions #(
  parameter int TICK_CYCLES = 20,
  parameter int RX_COUNT    = 10
) (
  input wire logic                          SYS_CLK_I,
  input wire logic                          RESETN_I,
  input wire logic                          WR_STROBE_I,
  input wire logic [15:0]                   WR_ADDR_I,
  input wire logic [RX_COUNT-1:0]           RX_ENABLE_I,
  input wire logic [RX_COUNT-1:0][15:0]     RX_ADDR_I,
  input wire logic [RX_COUNT-1:0][15:0]     RX_TIMEOUT_I,
  input wire logic [3:0]                    SEL_KIND_I,
  input wire logic [3:0]                    SEL_NUM_I,
  input wire logic                          SEL_BINARY_I,
  input wire logic [31:0]                   SEL_MIN_I,
  input wire logic [31:0]                   SEL_MAX_I,
  input wire logic [4:0][18:0]              TC_PARAM_ID_I,
  input wire logic [RX_COUNT-1:0]           RX_VALID_O,
  input wire logic [31:0]                   SEL_VALUE_O,
  input wire logic                          SEL_VALID_O,
  input wire logic                          SEL_USED_O,
  input wire logic                          SEL_BIT_O
);
  logic [31:0] age;
  logic        hit;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  assign hit = WR_STROBE_I && WR_ADDR_I == RX_ADDR_I[0];
  // Saturates so a long idle never wraps back to young
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) age <= 32'h0;
    else if (hit) age <= 32'h0;
    else if (age != 32'hFFFFFFFF) age <= age + 32'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    hit && RX_ENABLE_I[0] && RX_ADDR_I[0] >= wfx_pkg::ADDR_LO && RX_ADDR_I[0] <= wfx_pkg::ADDR_HI;
  endsequence
  sequence s_on3;
    RX_ENABLE_I[0] [*3];
  endsequence
  a_word_valid: assert property (s_take ##1 RX_ENABLE_I[0] [*2] |-> RX_VALID_O[0])
    else $error("stage zero not valid after word");
  a_rise_cause: assert property ($rose(RX_VALID_O[0]) |-> $past(hit, 2))
    else $error("stage zero valid without word");
  a_disable_clear: assert property (!RX_ENABLE_I[0] [*2] |-> !RX_VALID_O[0])
    else $error("disabled stage still valid");
  // Expiry is decided two edges before it shows, so the timeout two samples back counts too
  a_zero_tmo: assert property (s_on3 ##0 (RX_TIMEOUT_I[0] == 16'h0
    && $past(RX_TIMEOUT_I[0]) == 16'h0 && $past(RX_TIMEOUT_I[0], 2) == 16'h0
    && $past(RX_VALID_O[0])) |-> RX_VALID_O[0]) else $error("stale with timeout off");
  a_stale_late: assert property (RX_TIMEOUT_I[0] != 16'h0 && RX_VALID_O[0] |->
    age <= 32'(RX_TIMEOUT_I[0]) * TICK_CYCLES + 3) else $error("stale not flagged");
  a_stale_early: assert property (s_on3 ##0 ($fell(RX_VALID_O[0])
    && RX_TIMEOUT_I[0] != 16'h0) |-> age + TICK_CYCLES >= 32'(RX_TIMEOUT_I[0]) * TICK_CYCLES)
    else $error("stale too soon");
  a_unused_off: assert property (SEL_KIND_I == 4'h0 |=> !SEL_USED_O && !SEL_VALID_O
    && SEL_VALUE_O == 32'h0 && !SEL_BIT_O) else $error("unused source not silent");
  a_used_flag: assert property (SEL_KIND_I != 4'h0 |=> SEL_USED_O)
    else $error("used flag missing");
  a_bad_num: assert property (SEL_KIND_I == 4'hD && (SEL_NUM_I == 4'h0 || SEL_NUM_I > 4'hA)
    |=> !SEL_VALID_O && SEL_VALUE_O == 32'h0) else $error("bad instance accepted");
  a_tcode_pid: assert property (SEL_KIND_I == 4'h8 && SEL_NUM_I inside {[1:5]} |=>
    SEL_VALID_O == $past(TC_PARAM_ID_I[SEL_NUM_I - 4'h1] != 19'h0)) else $error("code validity");
  a_hyst_bit: assert property ($past(SEL_BINARY_I) && $past(SEL_BINARY_I, 2)
    && $past(SEL_KIND_I) == 4'hD && SEL_VALID_O && $past(SEL_VALID_O) |->
    ($signed(SEL_VALUE_O) <= $signed($past(SEL_MIN_I)) ? !SEL_BIT_O :
    $signed(SEL_VALUE_O) >= $signed($past(SEL_MAX_I)) ? SEL_BIT_O : SEL_BIT_O == $past(SEL_BIT_O)))
    else $error("binary interpretation wrong");
endmodule // wfx_assertions

// *** tb/wfx_client.sv ***
// Purpose: Network client writing holding registers
// Assumes: One strobe per word, words may follow back to back
// Notes: Released address and data show inverted last value
`timescale 1ns/1ps
module wfx_client (
  input  wire logic   clk_i,
  output logic        stb_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o
);
  initial begin
    stb_o = 1'b0;
    addr_o = 16'h0000;
    data_o = 16'h0000;
  end
  task automatic send(input logic [15:0] a, input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      stb_o <= 1'b1;
      addr_o <= a;
      data_o <= d + 16'(i);
    end
    @(posedge clk_i);
    stb_o <= 1'b0;
    addr_o <= ~a;
    data_o <= ~(d + 16'(n - 1));
  endtask
endmodule // wfx_client

// *** tb/test_wfx_top.sv ***
// Purpose: Self-checking bench for field extract and source select
// Assumes: Short millisecond tick so staleness fits a short run
// Notes: Selector limits are the documented instance ranges
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module test_wfx_top;
  localparam int T = 20;
  logic sys_clk = 1'b0, resetn = 1'b0, wr_stb, bin = 1'b0, sval, sused, sbit;
  logic [15:0] wr_addr, wr_data;
  logic [9:0] en = '0, rvld;
  logic [9:0][15:0] ra = '0, rres = '0, rtmo = '0;
  logic [9:0][4:0] rsz = '0;
  logic [9:0][3:0] rpos = '0;
  logic [9:0][31:0] roff = '0, rv;
  logic [3:0] kind = '0, num = '0;
  logic [31:0] smin = '0, smax = '0, so;
  logic [15:0][11:0][31:0] sv;
  logic [15:0][11:0] sen;
  logic [4:0][18:0] pid = '0;
  int n_errors = 0, num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  wfx_client cli_u (.clk_i(sys_clk), .stb_o(wr_stb), .addr_o(wr_addr), .data_o(wr_data));
  wfx_top #(.TICK_CYCLES(T)) dut_u (.SYS_CLK_I(sys_clk), .RESETN_I(resetn),
    .WR_STROBE_I(wr_stb), .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data), .RX_ENABLE_I(en),
    .RX_ADDR_I(ra), .RX_SIZE_I(rsz), .RX_POS_I(rpos), .RX_RES_I(rres), .RX_OFFSET_I(roff),
    .RX_TIMEOUT_I(rtmo), .SEL_KIND_I(kind), .SEL_NUM_I(num), .SEL_BINARY_I(bin),
    .SEL_MIN_I(smin), .SEL_MAX_I(smax), .SRC_VALUE_I(sv), .SRC_ENABLE_I(sen),
    .TC_PARAM_ID_I(pid), .RX_VALUE_O(rv), .RX_VALID_O(rvld), .SEL_VALUE_O(so),
    .SEL_VALID_O(sval), .SEL_USED_O(sused), .SEL_BIT_O(sbit));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xp(logic [15:0] d, int sz, int p, int r, int o);
    logic [15:0] m;
    m = 16'(((32'h1 << sz) - 32'h1) << p);
    return 32'(int'((d & m) >> p) * r + o);
  endfunction
  task automatic cfg(int i, logic [15:0] a, int sz, int p, int r, int o, int t);
    @(posedge sys_clk);
    en[i] <= 1'b1;
    ra[i] <= a;
    rsz[i] <= 5'(sz);
    rpos[i] <= 4'(p);
    rres[i] <= 16'(r);
    roff[i] <= 32'(o);
    rtmo[i] <= 16'(t);
  endtask
  task automatic off(int i);
    @(posedge sys_clk);
    en[i] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic put(logic [15:0] a, logic [15:0] d, int n, int w);
    cli_u.send(a, d, n);
    repeat (w) @(posedge sys_clk);
    #1;
  endtask
  task automatic sel(int k, int n);
    @(posedge sys_clk);
    kind <= 4'(k);
    num <= 4'(n);
    @(posedge sys_clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_extract();
    int sz [4] = '{16, 6, 1, 9};
    int ps [4] = '{0, 12, 15, 4};
    for (int k = 0; k < 4; k++) begin
      cfg(0, 16'h0120, sz[k], ps[k], -3, 100, 0);
      put(16'h0120, 16'hA5C3, 1, 2);
      `CHK("rx_value", xp(16'hA5C3, sz[k], ps[k], -3, 100), rv[0])
      `CHK("rx_valid", 1'b1, rvld[0])
    end
    cfg(0, 16'h0120, 16, 0, 1, 0, 0);
    put(16'h0120, 16'h0010, 3, 2);
    `CHK("rx_burst", 32'h12, rv[0])
    put(16'h0121, 16'h0777, 1, 2);
    `CHK("rx_other", 32'h12, rv[0])
    cfg(1, 16'h0200, 16, 0, 1, 0, 0);
    put(16'h0200, 16'h0005, 1, 2);
    `CHK("rx_window", 1'b0, rvld[1])
    off(0);
    `CHK("rx_off_valid", 1'b0, rvld[0])
    `CHK("rx_off_value", 32'h0, rv[0])
  endtask
  task automatic t_select();
    int lim [16] = '{0, 10, 0, 0, 4, 12, 6, 4, 5, 10, 10, 0, 0, 10, 0, 0};
    for (int k = 1; k < 13; k++) begin
      sel(k, lim[k]);
      `CHK("sel_value", 32'(k * 4096 + (lim[k] > 0 ? lim[k] : 1)), so)
      `CHK("sel_valid", 1'b1, sval)
      sel(k, lim[k] + 1);
      `CHK("sel_range", (lim[k] > 0) ? 1'b0 : 1'b1, sval)
    end
    sel(14, 1);
    `CHK("sel_bad_kind", 1'b0, sval)
    `CHK("sel_bad_used", 1'b1, sused)
    sel(0, 1);
    `CHK("sel_used", 1'b0, sused)
    sel(5, 3);
    `CHK("sel_fb_off", 1'b0, sval)
    sel(8, 2);
    `CHK("sel_tcode", 1'b0, sval)
  endtask
  task automatic t_hyst();
    int v [6] = '{25, 15, 10, 15, 20, 5};
    logic b [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    cfg(0, 16'h0120, 16, 0, 1, 0, 0);
    smin <= 32'h0000000A;
    smax <= 32'h00000014;
    bin <= 1'b1;
    sel(13, 1);
    for (int k = 0; k < 6; k++) begin
      put(16'h0120, 16'(v[k]), 1, 3);
      `CHK("sel_stage", 32'(v[k]), so)
      `CHK("sel_bit", b[k], sbit)
    end
    // Discrete source skips the thresholds
    sel(2, 0);
    `CHK("sel_disc_bit", 1'b1, sbit)
  endtask
  task automatic t_timeout();
    put(16'h0120, 16'h0007, 1, 200);
    `CHK("rx_tmo_zero", 1'b1, rvld[0])
    off(0);
    cfg(0, 16'h0120, 16, 0, 1, 0, 3);
    for (int k = 0; k < 4; k++) begin
      put(16'h0120, 16'(k), 1, 2 * T - 5);
      `CHK("rx_fresh", 1'b1, rvld[0])
    end
    repeat (2 * T + 30) @(posedge sys_clk);
    #1;
    `CHK("rx_stale", 1'b0, rvld[0])
    `CHK("rx_stale_value", 32'h00000003, rv[0])
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int k = 0; k < 16; k++)
      for (int n = 0; n < 12; n++)
        sv[k][n] = 32'(k * 4096 + n + 1);
    sen = '1;
    sen[5][2] = 1'b0;
    pid[4] = 19'h1;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_extract();
    t_select();
    t_hyst();
    t_timeout();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end
endmodule // test_wfx_top
bind wfx_top wfx_assertions #(.TICK_CYCLES(TICK_CYCLES), .RX_COUNT(RX_COUNT)) chk_u (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .WR_STROBE_I(WR_STROBE_I), .WR_ADDR_I(WR_ADDR_I),
  .RX_ENABLE_I(RX_ENABLE_I), .RX_ADDR_I(RX_ADDR_I), .RX_TIMEOUT_I(RX_TIMEOUT_I),
  .SEL_KIND_I(SEL_KIND_I), .SEL_NUM_I(SEL_NUM_I), .SEL_BINARY_I(SEL_BINARY_I),
  .SEL_MIN_I(SEL_MIN_I), .SEL_MAX_I(SEL_MAX_I), .TC_PARAM_ID_I(TC_PARAM_ID_I),
  .RX_VALID_O(RX_VALID_O), .SEL_VALUE_O(SEL_VALUE_O), .SEL_VALID_O(SEL_VALID_O),
  .SEL_USED_O(SEL_USED_O), .SEL_BIT_O(SEL_BIT_O));
